// file: dpsg_top.sv
// dram power-state gating register bank top
`timescale 1ns/1ps
`include "dpsg_defines.svh"

module dpsg_top
  import dpsg_pkg::*;
(
  input  wire logic         ref_clk,        // core clock, 125 mhz
  input  wire logic         rst,            // cold reset, sync, high
  input  wire logic         warm_rst,       // platform warm reset level
  input  wire logic         wr_en,          // register write strobe
  input  wire logic         rd_en,          // register read strobe
  input  wire logic [11:0]  addr,           // byte offset in window
  input  wire logic [15:0]  wr_data,        // write data
  input  wire logic [4:0]   cstate,         // one-hot processor c state
  input  wire logic         srf_other_ok,   // other self-refresh conditions
  input  wire logic         sdll_other_ok,  // other dll power-down conditions
  output logic      [15:0]  rd_data,        // read data, registered
  output logic              rd_valid,       // read data valid pulse
  output logic              srf_allow,      // self-refresh may start
  output logic              sdll_allow,     // slave dll may power down
  output logic              warm_clr        // gate registers reloaded
);

  logic [1:0]  warm_sync_r;
  logic        warm_prev_r;
  logic        retain_r;
  logic [15:0] srf_val;
  logic [15:0] sdll_val;
  logic        srf_ok;
  logic        sdll_ok;
  logic        warm_edge;
  logic        warm_clr_nxt;
  logic        hit_retain;
  logic        hit_srf;
  logic        hit_sdll;
  logic [15:0] rd_nxt;
  logic        wr_retain;
  logic        wr_srf;
  logic        wr_sdll;
  logic [2:0]  srf_code;
  logic [2:0]  sdll_code;

  // -------------------------------------------------------------
  // warm reset pin synchroniser and assertion edge
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warm_sync_r <= 2'h0;
      warm_prev_r <= 1'b0;
    end else begin
      warm_sync_r <= {warm_sync_r[0], warm_rst};
      warm_prev_r <= warm_sync_r[1];
    end
  end

  assign warm_edge    = warm_sync_r[1] && !warm_prev_r;
  assign warm_clr_nxt = warm_edge && !retain_r;

  // -------------------------------------------------------------
  // sticky retention bit, cleared by cold reset or a write of zero
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      retain_r <= 1'b0;
    end else if (wr_retain) begin
      retain_r <= wr_data[`DPSG_RETAIN_BIT];
    end
  end

  // -------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------
  assign hit_retain = (addr == `DPSG_OFS_RETAIN);
  assign hit_srf    = (addr == `DPSG_OFS_SRF);
  assign hit_sdll   = (addr == `DPSG_OFS_SDLL);

  // per-register write strobes and the gate codes held
  assign wr_retain  = wr_en && hit_retain;
  assign wr_srf     = wr_en && hit_srf;
  assign wr_sdll    = wr_en && hit_sdll;
  assign srf_code   = srf_val[`DPSG_GATE_HI:`DPSG_GATE_LO];
  assign sdll_code  = sdll_val[`DPSG_GATE_HI:`DPSG_GATE_LO];

  // -------------------------------------------------------------
  // the two gate registers
  // -------------------------------------------------------------
  dpsg_gate_reg u_srf (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .warm_clr (warm_clr_nxt),
    .wr_en    (wr_srf),
    .wr_data  (wr_data),
    .cstate   (cstate),
    .rd_value (srf_val),
    .state_ok (srf_ok)
  );

  dpsg_gate_reg u_sdll (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .warm_clr (warm_clr_nxt),
    .wr_en    (wr_sdll),
    .wr_data  (wr_data),
    .cstate   (cstate),
    .rd_value (sdll_val),
    .state_ok (sdll_ok)
  );

  // -------------------------------------------------------------
  // read mux, unmapped offsets read zero
  // -------------------------------------------------------------
  assign rd_nxt = hit_retain ? {1'b0, retain_r, 14'h0000} :
                  hit_srf    ? srf_val :
                  hit_sdll   ? sdll_val : `DPSG_REG_RST;

  // -------------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data    <= `DPSG_REG_RST;
      rd_valid   <= 1'b0;
      srf_allow  <= 1'b0;
      sdll_allow <= 1'b0;
      warm_clr   <= 1'b0;
    end else begin
      rd_data    <= rd_en ? rd_nxt : rd_data;
      rd_valid   <= rd_en;
      srf_allow  <= srf_ok && srf_other_ok;
      sdll_allow <= sdll_ok && sdll_other_ok;
      warm_clr   <= warm_clr_nxt;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  // warm reset assertion edge as the bank sees it
  sequence s_warm_hit;
    !warm_prev_r && warm_sync_r[1];
  endsequence

  // edge while the retention bit holds and no write lands
  sequence s_warm_kept;
    s_warm_hit ##0 (retain_r && !wr_en);
  endsequence

  // edge with the retention bit clear
  sequence s_warm_clear;
    s_warm_hit ##0 !retain_r;
  endsequence

  // reload pulse with both gates back at their defaults
  sequence s_reloaded;
    warm_clr && srf_val == `DPSG_REG_RST && sdll_val == `DPSG_REG_RST;
  endsequence

  a_retain_holds: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_warm_kept |=> !warm_clr && $stable(srf_val))
    else $error("warm reset cleared registers while retained");

  a_sdll_retained: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_warm_kept |=> $stable(sdll_val))
    else $error("warm reset cleared dll gate while retained");

  a_warm_clears: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_warm_clear |=> s_reloaded)
    else $error("warm reset did not reload defaults");

  a_clr_one_pulse: assert property (
    @(posedge ref_clk) disable iff (rst)
    warm_clr |=> !warm_clr)
    else $error("reload pulse longer than one cycle");

  a_retain_sticky: assert property (
    @(posedge ref_clk) disable iff (rst)
    !wr_retain |=> $stable(retain_r))
    else $error("retention bit changed without a write");

  a_retain_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_retain && wr_data[`DPSG_RETAIN_BIT]) |=> retain_r)
    else $error("retention bit write of one lost");

  a_retain_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_retain && !wr_data[`DPSG_RETAIN_BIT]) |=> !retain_r)
    else $error("retention bit write of zero lost");

  a_retain_read: assert property (
    @(posedge ref_clk) disable iff (rst)
    (rd_en && hit_retain) |=>
      rd_valid && rd_data[`DPSG_RETAIN_BIT] == $past(retain_r))
    else $error("retention bit read back wrong");

  a_srf_needs_both: assert property (
    @(posedge ref_clk) disable iff (rst)
    srf_allow |-> $past(srf_ok) && $past(srf_other_ok))
    else $error("self-refresh allowed without its conditions");

  a_sdll_needs_both: assert property (
    @(posedge ref_clk) disable iff (rst)
    sdll_allow |-> $past(sdll_ok) && $past(sdll_other_ok))
    else $error("dll power-down allowed without its conditions");

  a_srf_c34_only: assert property (
    @(posedge ref_clk) disable iff (rst)
    srf_allow |-> $past(srf_code) == `DPSG_GATE_C34)
    else $error("self-refresh allowed with gate not 110");

  a_sdll_gate_110: assert property (
    @(posedge ref_clk) disable iff (rst)
    sdll_allow |-> $past(sdll_code) == `DPSG_GATE_C34)
    else $error("dll power-down allowed with gate not 110");

  a_srf_state_c34: assert property (
    @(posedge ref_clk) disable iff (rst)
    srf_allow |-> $past(cstate) == DPSG_C3 || $past(cstate) == DPSG_C4)
    else $error("self-refresh allowed outside c3 and c4");

  a_sdll_c34_only: assert property (
    @(posedge ref_clk) disable iff (rst)
    sdll_allow |-> $past(cstate) == DPSG_C3 || $past(cstate) == DPSG_C4)
    else $error("dll power-down allowed outside c3 and c4");

  a_srf_allow_on: assert property (
    @(posedge ref_clk) disable iff (rst)
    (srf_ok && srf_other_ok) |=> srf_allow)
    else $error("self-refresh withheld although permitted");

  a_sdll_allow_on: assert property (
    @(posedge ref_clk) disable iff (rst)
    (sdll_ok && sdll_other_ok) |=> sdll_allow)
    else $error("dll power-down withheld although permitted");

  a_read_pulse: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_en |=> rd_valid)
    else $error("read valid mistimed");

  a_cold_default: assert property (
    @(posedge ref_clk)
    rst |=> !retain_r && !srf_allow && !sdll_allow && !warm_clr)
    else $error("cold reset left state set");

endmodule

// file: dpsg_defines.svh
// constants of the dram power-state gating register bank
// Operation
// - Retention clear: warm reset reloads both gate registers to defaults.
// - Retention set: warm reset leaves the window registers as they are.
// - Retention bit: read/write, cold reset clears it, warm reset keeps it.
// - Self-refresh gate 6:4: 000 (reset) never allows, 110 only in C3 and C4.
// - Slave dll gate 6:4: 000 (reset) never allows, 110 only in C3 and C4.
// - C-state gate is a precondition; other entry conditions must hold too.
`ifndef DPSG_DEFINES_SVH
`define DPSG_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets inside the config window
// ----------------------------------------------------------------
`define DPSG_OFS_RETAIN   12'hc16
`define DPSG_OFS_SRF      12'hf08
`define DPSG_OFS_SDLL     12'hf0a

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DPSG_RETAIN_BIT   14
`define DPSG_GATE_HI      6
`define DPSG_GATE_LO      4
`define DPSG_RSV_HI       14
`define DPSG_RSV_LO       13
`define DPSG_LOW_HI       3
`define DPSG_GATE_RST     3'h0
`define DPSG_GATE_C34     3'h6
`define DPSG_RSV_RST      2'h0
`define DPSG_LOW_RST      4'h0
`define DPSG_REG_RST      16'h0000

`endif

// file: dpsg_pkg.sv
// types of the dram power-state gating register bank
package dpsg_pkg;

  // processor acpi c state, one-hot
  typedef enum logic [4:0] {
    DPSG_C0 = 5'h01,
    DPSG_C1 = 5'h02,
    DPSG_C2 = 5'h04,
    DPSG_C3 = 5'h08,
    DPSG_C4 = 5'h10
  } dpsg_cstate_e;

  typedef logic [15:0] dpsg_word_t;

endpackage

// file: dpsg_gate_reg.sv
// one c-state gate register with its allow decode
`timescale 1ns/1ps
`include "dpsg_defines.svh"

module dpsg_gate_reg
  import dpsg_pkg::*;
(
  input  wire logic         ref_clk,     // core clock
  input  wire logic         rst,         // cold reset
  input  wire logic         warm_clr,    // warm reset that reloads defaults
  input  wire logic         wr_en,       // write strobe for this register
  input  wire logic [15:0]  wr_data,     // write data
  input  wire logic [4:0]   cstate,      // one-hot c state
  output logic      [15:0]  rd_value,    // read view
  output logic              state_ok     // c-state precondition met
);

  logic [2:0] gate_r;
  logic [1:0] rsv_r;
  logic [3:0] low_r;

  // -------------------------------------------------------------
  // storage, cold or enabled warm reset reloads defaults
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || warm_clr) begin
      gate_r <= `DPSG_GATE_RST;
      rsv_r  <= `DPSG_RSV_RST;
      low_r  <= `DPSG_LOW_RST;
    end else if (wr_en) begin
      gate_r <= wr_data[`DPSG_GATE_HI:`DPSG_GATE_LO];
      rsv_r  <= wr_data[`DPSG_RSV_HI:`DPSG_RSV_LO];
      low_r  <= wr_data[`DPSG_LOW_HI:0];
    end
  end

  // -------------------------------------------------------------
  // read view and decode; reserved codes never allow
  // -------------------------------------------------------------
  assign rd_value = {1'b0, rsv_r, 6'h00, gate_r, low_r};
  assign state_ok = (gate_r == `DPSG_GATE_C34) &&
                    (cstate == DPSG_C3 || cstate == DPSG_C4);

  a_gate_default: assert property (
    @(posedge ref_clk)
    (rst || warm_clr) |=> !state_ok && rd_value == `DPSG_REG_RST)
    else $error("gate not back to default after reset");
  a_gate_c0_never: assert property (
    @(posedge ref_clk) disable iff (rst)
    (cstate == DPSG_C0) |-> !state_ok)
    else $error("gate allowed in c0");

endmodule

// file: dpsg_cpu_model.sv
// processor c-state and platform condition model
`timescale 1ns/1ps

module dpsg_cpu_model (
  input  wire logic        ref_clk,        // core clock
  input  wire logic        rst,            // cold reset, back to c0
  input  wire logic        req,            // new state request
  input  wire logic [2:0]  req_c,          // requested c state number
  input  wire logic [1:0]  req_ok,         // other conditions srf, sdll
  output logic      [4:0]  cstate,         // one-hot c state
  output logic             srf_other_ok,   // other self-refresh conditions
  output logic             sdll_other_ok   // other dll power-down conditions
);
  // reset to c0 with no other entry condition met, then follow requests
  always @(posedge ref_clk) begin
    if (rst) begin
      cstate        <= 5'h01;
      srf_other_ok  <= 1'b0;
      sdll_other_ok <= 1'b0;
    end else if (req) begin
      cstate        <= 5'h01 << req_c;
      srf_other_ok  <= req_ok[1];
      sdll_other_ok <= req_ok[0];
    end
  end
endmodule

// file: tb_top.sv
// self-checking bench of the dram power-state gating bank
`timescale 1ns/1ps
`include "dpsg_defines.svh"

module tb_top;
  import dpsg_pkg::*;
  logic        ref_clk = 0, rst = 1, warm_rst = 0, wr_en = 0, rd_en = 0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wr_data = 16'h0000;
  logic        req = 0;
  logic [2:0]  req_c = 3'h0;
  logic [1:0]  req_ok = 2'h0;
  logic [4:0]  cstate;
  logic        srf_ok, sdll_ok, rd_valid, srf_allow, sdll_allow, warm_clr;
  logic [15:0] rd_data;
  int          num_errors = 0, num_checks = 0;
  int          m_srf = 0, m_sdll = 0, m_ret = 0, k;

  // core clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  dpsg_top dut (.ref_clk(ref_clk), .rst(rst), .warm_rst(warm_rst),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .cstate(cstate), .srf_other_ok(srf_ok), .sdll_other_ok(sdll_ok),
    .rd_data(rd_data), .rd_valid(rd_valid), .srf_allow(srf_allow),
    .sdll_allow(sdll_allow), .warm_clr(warm_clr));
  dpsg_cpu_model cpu (.ref_clk(ref_clk), .rst(rst), .req(req),
    .req_c(req_c), .req_ok(req_ok), .cstate(cstate), .srf_other_ok(srf_ok),
    .sdll_other_ok(sdll_ok));

  task final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wr_en <= 1; addr <= a; wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 0;
  endtask

  // read strobe, bounded wait for the valid pulse, then compare
  task rd(input logic [11:0] a, input logic [15:0] e);
    int i;
    i = 0;
    @(posedge ref_clk);
    rd_en <= 1; addr <= a;
    @(posedge ref_clk);
    rd_en <= 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (rd_valid !== 1'b1 && i < 4);
    if (rd_valid !== 1'b1) begin
      chk("rd_valid", 16'h1, 16'h0);
      final_report;
    end else begin
      chk("rd_data", e, rd_data);
    end
  endtask

  task regs;
    rd(`DPSG_OFS_SRF, 16'(m_srf << 4));
    rd(`DPSG_OFS_SDLL, 16'(m_sdll << 4));
    rd(`DPSG_OFS_RETAIN, 16'(m_ret << 14));
  endtask

  task allow(input int c, input int os, input int od);
    @(posedge ref_clk);
    req <= 1; req_c <= c[2:0]; req_ok <= {os[0], od[0]};
    @(posedge ref_clk);
    req <= 0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("srf_allow", {15'h0, m_srf == 6 && c >= 3 && os == 1},
        {15'h0, srf_allow});
    chk("sdll_allow", {15'h0, m_sdll == 6 && c >= 3 && od == 1},
        {15'h0, sdll_allow});
  endtask

  // warm reset: one reload pulse only when retention is clear
  task warm;
    int i, seen;
    seen = 0;
    @(posedge ref_clk);
    warm_rst <= 1;
    for (i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      if (warm_clr === 1'b1) seen++;
    end
    chk("warm_clr", 16'(m_ret == 0), 16'(seen));
    @(posedge ref_clk);
    warm_rst <= 0;
    repeat (4) @(posedge ref_clk);
    if (m_ret == 0) begin
      m_srf = 0;
      m_sdll = 0;
    end
    regs;
  endtask

  // main sequence
  initial begin
    void'($urandom(94087));
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    regs;
    wr(12'h100, 16'hffff);
    rd(12'h100, 16'h0000);
    for (k = 0; k < 14; k++) begin
      m_srf = (k < 5 || $urandom % 2) ? 6 : 0;
      m_sdll = (k < 5 || $urandom % 2) ? 6 : 0;
      wr(`DPSG_OFS_SRF, 16'(m_srf << 4));
      wr(`DPSG_OFS_SDLL, 16'(m_sdll << 4));
      allow(k % 5, k < 5 ? 1 : $urandom % 2, $urandom % 2);
    end
    m_ret = 1; m_srf = 6; m_sdll = 6;
    wr(`DPSG_OFS_RETAIN, 16'h4000);
    wr(`DPSG_OFS_SRF, 16'h0060);
    wr(`DPSG_OFS_SDLL, 16'h0060);
    warm;
    m_ret = 0;
    wr(`DPSG_OFS_RETAIN, 16'h0000);
    warm;
    m_ret = 1;
    m_srf = 6;
    wr(`DPSG_OFS_RETAIN, 16'h4000);
    wr(`DPSG_OFS_SRF, 16'h0060);
    regs;
    @(posedge ref_clk);
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    m_ret = 0;
    m_srf = 0;
    regs;
    final_report;
  end
endmodule
